// [pkg/csw_pkg.sv]
// Types shared by the clock source switch
package csw_pkg;

    // Device clock sources
    typedef enum logic [1:0] {
        CSW_SRC_PRI,
        CSW_SRC_SEC,
        CSW_SRC_INT
    } csw_src_e;

    // Glitch-free switch sequence
    typedef enum logic [1:0] {
        CSW_ST_RUN,
        CSW_ST_OLD,
        CSW_ST_WAIT,
        CSW_ST_NEW
    } csw_state_e;

endpackage

// [pkg/csw_regs.svh]
// Register offsets, field positions, reset values and switch timing counts
`ifndef CSW_REGS_SVH
`define CSW_REGS_SVH

// Oscillator control register address
`define CSW_OSC_CTRL_ADDR     12'hfd3

// Field positions inside the oscillator control register
`define CSW_IDLE_BIT          7
`define CSW_IFS_HI            6
`define CSW_IFS_LO            4
`define CSW_STATUS_BIT        3
`define CSW_FIXED_BIT         2
`define CSW_SCS_HI            1
`define CSW_SCS_LO            0

// Reset values
`define CSW_IDLE_RST          1'b0
`define CSW_IFS_RST           3'b110
`define CSW_SCS_RST           2'b00
`define CSW_FIXED_VAL         1'b1

// Source select codes
`define CSW_SCS_PRI           2'b00
`define CSW_SCS_SEC           2'b01
`define CSW_SCS_RSV           2'b10
`define CSW_SCS_INT           2'b11

// Internal frequency codes with special meaning
`define CSW_IFS_DIRECT        3'b111
`define CSW_IFS_LOW           3'b000

// Edges of the old and new source during a pause
`define CSW_OLD_EDGES         2'd2
`define CSW_NEW_EDGES         2'd3

`endif

// [rtl/csw_clock_switch.sv]
// System clock source switch with oscillator control register
//
// What this block does
// - Select field picks primary, secondary or internal clock
// - Writing select field starts the glitch-free switch next cycle, or after a running switch ends
// - Every reset returns select field to primary
// - Frequency field sets postscaled internal clock rate
// - Frequency write changes internal output immediately
// - Frequency field resets to 4 MHz setting
// - 31 kHz from fast osc divided or RC
// - Watchdog clock always from slow RC
// - Startup status reads 1 when primary ready
// - Primary and secondary running flags never both set
// - Idle select chooses idle or sleep mode
// - Secondary select ignored unless enabled or digital
// - Glitch-free pause: two old, three new edges
// - Startup status resets to inverse of two-speed
// - Bit two reads one, ignores writes
// - Primary path uses postscaler or CPU divider
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
`include "csw_regs.svh"
module csw_clock_switch #(
    parameter int unsigned ADDR_W = 12
) (
    input  logic              clock_i,                          // System clock, 100 MHz
    input  logic              reset_n_i,                        // Asynchronous reset, active low
    input  logic [ADDR_W-1:0] addr_i,                           // Register address
    input  logic [7:0]        wdata_i,                          // Register write data
    input  logic              wr_i,                             // Write strobe
    input  logic              rd_i,                             // Read strobe
    output logic [7:0]        rdata_o,                          // Read data, cycle after strobe
    input  logic [2:0]        primary_mode_config_i,            // Primary oscillator mode
    input  logic              two_speed_startup_i,              // Two-speed start-up enabled
    input  logic              low_freq_source_select_i,         // 31 kHz from fast osc when set
    input  logic              secondary_osc_enable_i,           // Secondary crystal driver on
    input  logic              secondary_digital_input_allow_i,  // Digital secondary input allowed
    input  logic              sleep_exec_i,                     // Sleep instruction executed
    input  logic              fast_internal_osc_i,              // Fast internal oscillator
    input  logic              slow_internal_rc_i,               // Slow internal RC oscillator
    input  logic              secondary_osc_i,                  // Secondary crystal oscillator
    input  logic              cpu_div_clk_i,                    // CPU divider output
    input  logic              startup_timer_done_i,             // Start-up timer expired
    input  logic              secondary_osc_stable_i,           // Secondary oscillator stable
    input  logic              fast_osc_stable_i,                // Fast internal osc stable
    output logic              sysclk_o,                         // Device clock level
    output logic              wdt_clk_o,                        // Watchdog and monitor clock
    output logic              secondary_clock_active_o,         // Secondary drives device clock
    output logic              enter_idle_o,                     // Pulse: enter idle mode
    output logic              enter_sleep_o                     // Pulse: enter sleep mode
);

    localparam int unsigned NPIN = 7;
    localparam int unsigned P_FAST = 0;
    localparam int unsigned P_SLOW = 1;
    localparam int unsigned P_SEC = 2;
    localparam int unsigned P_CPU = 3;
    localparam int unsigned P_OST = 4;
    localparam int unsigned P_SSTB = 5;
    localparam int unsigned P_FSTB = 6;

    // Address must reach the register offset
    if (ADDR_W < 12) begin : g_chk
        $error("csw_clock_switch needs ADDR_W of at least 12");
    end

    logic [NPIN-1:0]         pin_s;
    logic                    idle_q;
    logic [2:0]              ifs_q;
    logic [1:0]              scs_q;
    logic                    status_q;
    logic                    init_q;
    logic [7:0]              ps_cnt_q;
    logic                    fast_prev_q;
    logic [2:0]              lvl_prev_q;
    logic [2:0]              lvl;
    logic [2:0]              edge_v;
    logic                    ps_lvl;
    logic                    pri_lvl;
    logic                    int_stable;
    logic [2:0]              stable_v;
    csw_pkg::csw_src_e       cur_q;
    csw_pkg::csw_src_e       new_q;
    csw_pkg::csw_src_e       target;
    csw_pkg::csw_state_e     st_q;
    logic [1:0]              ecnt_q;
    logic                    sysclk_q;
    logic                    hit;

    // Postscaler shift for each frequency code; 8 means divide by 256
    function automatic logic [3:0] ifs_shift(input logic [2:0] code);
        logic [3:0] k;
        k = 4'h7 - {1'b0, code};
        if (code == `CSW_IFS_LOW) begin
            k = 4'h8;
        end
        return k;
    endfunction

    // Pick one source's bit out of a per-source vector
    function automatic logic pick(input logic [2:0] v, input csw_pkg::csw_src_e s);
        logic b;
        b = 1'b0;
        case (s)
            csw_pkg::CSW_SRC_PRI: b = v[0];
            csw_pkg::CSW_SRC_SEC: b = v[1];
            csw_pkg::CSW_SRC_INT: b = v[2];
            default:              b = 1'b0;
        endcase
        return b;
    endfunction

    // All oscillator and status pins enter through the filter
    csw_sync #(
        .W (NPIN)
    ) u_sync (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .async_i   ({fast_osc_stable_i, secondary_osc_stable_i, startup_timer_done_i,
                     cpu_div_clk_i, secondary_osc_i, slow_internal_rc_i,
                     fast_internal_osc_i}),
        .sync_o    (pin_s)
    );

    assign hit = (addr_i == ADDR_W'(`CSW_OSC_CTRL_ADDR));

    // Writable fields of the control register
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            idle_q <= `CSW_IDLE_RST;
            ifs_q  <= `CSW_IFS_RST;
            scs_q  <= `CSW_SCS_RST;
        end else if (wr_i && hit) begin
            idle_q <= wdata_i[`CSW_IDLE_BIT];
            ifs_q  <= wdata_i[`CSW_IFS_HI:`CSW_IFS_LO];
            if (!(wdata_i[`CSW_SCS_HI:`CSW_SCS_LO] == `CSW_SCS_SEC &&
                  !secondary_osc_enable_i && !secondary_digital_input_allow_i)) begin
                scs_q <= wdata_i[`CSW_SCS_HI:`CSW_SCS_LO];
            end
        end
    end

    // Read port; the fixed bit always reads one, other addresses read zero
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= hit ? {idle_q, ifs_q, status_q, `CSW_FIXED_VAL, scs_q} : 8'h00;
        end
    end

    // Start-up status: strap caught after release, then tracks primary
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            init_q   <= 1'b0;
            status_q <= 1'b0;
        end else if (!init_q) begin
            init_q   <= 1'b1;
            status_q <= !two_speed_startup_i;
        end else begin
            status_q <= pin_s[P_OST] && cur_q == csw_pkg::CSW_SRC_PRI
                        && st_q == csw_pkg::CSW_ST_RUN;
        end
    end

    // Postscaler counter advances on each fast oscillator rising edge
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ps_cnt_q    <= 8'h00;
            fast_prev_q <= 1'b0;
        end else begin
            fast_prev_q <= pin_s[P_FAST];
            if (pin_s[P_FAST] && !fast_prev_q) begin
                ps_cnt_q <= ps_cnt_q + 8'h01;
            end
        end
    end

    // Postscaled internal clock follows the frequency field combinationally
    always_comb begin
        ps_lvl = pin_s[P_FAST];
        if (ifs_q == `CSW_IFS_LOW && !low_freq_source_select_i) begin
            ps_lvl = pin_s[P_SLOW];
        end else if (ifs_q != `CSW_IFS_DIRECT) begin
            ps_lvl = ps_cnt_q[3'(ifs_shift(ifs_q) - 4'h1)];
        end
    end

    // Primary path by primary mode configuration
    assign pri_lvl = (primary_mode_config_i[2:1] == 2'b00) ? ps_lvl : pin_s[P_CPU];
    assign lvl     = {ps_lvl, pin_s[P_SEC], pri_lvl};
    assign edge_v  = lvl & ~lvl_prev_q;

    // Stability of each source
    assign int_stable = (ifs_q == `CSW_IFS_LOW && !low_freq_source_select_i) || pin_s[P_FSTB];
    assign stable_v   = {int_stable, pin_s[P_SSTB],
                         (primary_mode_config_i[2:1] == 2'b00) ? int_stable : pin_s[P_OST]};

    // Select field to source; reserved code keeps the running source
    always_comb begin
        case (scs_q)
            `CSW_SCS_PRI: target = csw_pkg::CSW_SRC_PRI;
            `CSW_SCS_SEC: target = csw_pkg::CSW_SRC_SEC;
            `CSW_SCS_INT: target = csw_pkg::CSW_SRC_INT;
            default:      target = cur_q;
        endcase
    end

    // Previous levels for edge detection
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lvl_prev_q <= 3'b000;
        end else begin
            lvl_prev_q <= lvl;
        end
    end

    // Glitch-free switch sequence
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q   <= csw_pkg::CSW_ST_RUN;
            cur_q  <= csw_pkg::CSW_SRC_PRI;
            new_q  <= csw_pkg::CSW_SRC_PRI;
            ecnt_q <= 2'd0;
        end else begin
            case (st_q)
                csw_pkg::CSW_ST_RUN: begin
                    if (target != cur_q) begin
                        st_q   <= csw_pkg::CSW_ST_OLD;
                        new_q  <= target;
                        ecnt_q <= 2'd0;
                    end
                end
                csw_pkg::CSW_ST_OLD: begin
                    if (pick(edge_v, cur_q)) begin
                        ecnt_q <= ecnt_q + 2'd1;
                        if (ecnt_q == `CSW_OLD_EDGES - 2'd1) begin
                            st_q   <= csw_pkg::CSW_ST_WAIT;
                            ecnt_q <= 2'd0;
                        end
                    end
                end
                csw_pkg::CSW_ST_WAIT: begin
                    if (pick(stable_v, new_q)) begin
                        st_q <= csw_pkg::CSW_ST_NEW;
                    end
                end
                csw_pkg::CSW_ST_NEW: begin
                    if (pick(edge_v, new_q)) begin
                        ecnt_q <= ecnt_q + 2'd1;
                        if (ecnt_q == `CSW_NEW_EDGES - 2'd1) begin
                            st_q   <= csw_pkg::CSW_ST_RUN;
                            cur_q  <= new_q;
                            ecnt_q <= 2'd0;
                        end
                    end
                end
                default: begin
                    st_q <= csw_pkg::CSW_ST_RUN;
                end
            endcase
        end
    end

    // Device clock held low while switching
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sysclk_q <= 1'b0;
        end else begin
            sysclk_q <= (st_q == csw_pkg::CSW_ST_RUN) && pick(lvl, cur_q);
        end
    end
    assign sysclk_o = sysclk_q;

    // Watchdog clock and secondary running flag
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wdt_clk_o                <= 1'b0;
            secondary_clock_active_o <= 1'b0;
        end else begin
            wdt_clk_o                <= pin_s[P_SLOW];
            secondary_clock_active_o <= cur_q == csw_pkg::CSW_SRC_SEC
                                        && st_q == csw_pkg::CSW_ST_RUN;
        end
    end

    // Sleep instruction outcome
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            enter_idle_o  <= 1'b0;
            enter_sleep_o <= 1'b0;
        end else begin
            enter_idle_o  <= sleep_exec_i && idle_q;
            enter_sleep_o <= sleep_exec_i && !idle_q;
        end
    end

    // Checks
    sel_switch_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        st_q == csw_pkg::CSW_ST_RUN && scs_q == `CSW_SCS_INT && cur_q != csw_pkg::CSW_SRC_INT
        |=> st_q == csw_pkg::CSW_ST_OLD && new_q == csw_pkg::CSW_SRC_INT)
        else $error("select write did not start a switch");

    pause_low_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        st_q != csw_pkg::CSW_ST_RUN |=> !sysclk_q)
        else $error("device clock ran during a switch");

    old_edges_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        st_q == csw_pkg::CSW_ST_OLD && ecnt_q == 2'd1 && pick(edge_v, cur_q)
        |=> st_q == csw_pkg::CSW_ST_WAIT)
        else $error("old source edge count wrong");

    wait_stable_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        st_q == csw_pkg::CSW_ST_WAIT && !pick(stable_v, new_q)
        |=> st_q == csw_pkg::CSW_ST_WAIT)
        else $error("switch left wait before new source stable");

    sec_ignore_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        wr_i && hit && wdata_i[1:0] == `CSW_SCS_SEC && !secondary_osc_enable_i
        && !secondary_digital_input_allow_i |=> scs_q == $past(scs_q))
        else $error("disabled secondary select was accepted");

    fixed_bit_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        rd_i && hit |=> rdata_o[`CSW_FIXED_BIT] && rdata_o[1:0] == $past(scs_q))
        else $error("fixed bit or select field read wrong");

    lowfreq_rc_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        ifs_q == `CSW_IFS_LOW && !low_freq_source_select_i |-> ps_lvl == pin_s[P_SLOW])
        else $error("31 kHz setting not from slow RC");

    wdt_clock_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        ##1 wdt_clk_o == $past(pin_s[P_SLOW]))
        else $error("watchdog clock not from slow RC");

    run_flags_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        init_q |-> !(secondary_clock_active_o && status_q))
        else $error("both running flags set");

    sleep_mode_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        sleep_exec_i |=> enter_idle_o == $past(idle_q) && enter_sleep_o != $past(idle_q))
        else $error("sleep instruction entered wrong mode");

    cpu_path_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        st_q == csw_pkg::CSW_ST_RUN && cur_q == csw_pkg::CSW_SRC_PRI
        && primary_mode_config_i[2:1] != 2'b00 |=> sysclk_q == $past(pin_s[P_CPU]))
        else $error("primary path not from CPU divider");

endmodule

// [rtl/csw_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module csw_sync #(
    parameter int unsigned W = 1
) (
    input  logic         clock_i,    // System clock
    input  logic         reset_n_i,  // Asynchronous reset, active low
    input  logic [W-1:0] async_i,    // Inputs from other domains
    output logic [W-1:0] sync_o      // Filtered synchronous copy
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // Refuse an empty vector
    if (W < 1) begin : g_chk
        $error("csw_sync needs W of at least 1");
    end

    // Three flip-flop chain; only the second stage reads the first
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts once the second and third stages agree
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync_o <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    sync_o[i] <= s3_q[i];
                end
            end
        end
    end

endmodule

// [testbench/csw_testbench.sv]
// Self-checking bench for the clock source switch and its control register
`timescale 1ns/1ns
`include "csw_regs.svh"
module testbench;
    logic        clock_i, reset_n_i, wr_i, rd_i, two_speed_i, low_freq_i, sec_en_i, dig_i;
    logic        sleep_i, fast_i, slow_i, sec_i, cpu_i, done_i, sec_ok_i, fast_ok_i;
    logic        sysclk_o, wdt_o, sec_act_o, idle_o, sleep_o, sys_q, wdt_q;
    logic [11:0] addr_i;
    logic [7:0]  wdata_i, rdata_o, rv;
    logic [2:0]  mode_i;
    int          failures, samples_checked, cycles, n, wdt_rises;

    csw_clock_switch uut (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .primary_mode_config_i(mode_i),
        .two_speed_startup_i(two_speed_i), .low_freq_source_select_i(low_freq_i),
        .secondary_osc_enable_i(sec_en_i), .secondary_digital_input_allow_i(dig_i),
        .sleep_exec_i(sleep_i), .fast_internal_osc_i(fast_i), .slow_internal_rc_i(slow_i),
        .secondary_osc_i(sec_i), .cpu_div_clk_i(cpu_i), .startup_timer_done_i(done_i),
        .secondary_osc_stable_i(sec_ok_i), .fast_osc_stable_i(fast_ok_i), .sysclk_o(sysclk_o),
        .wdt_clk_o(wdt_o), .secondary_clock_active_o(sec_act_o), .enter_idle_o(idle_o),
        .enter_sleep_o(sleep_o));

    // System clock and free-running oscillators with unrelated phases
    initial begin clock_i = 0; forever #5 clock_i = ~clock_i; end
    initial begin fast_i = 0; #3 forever #40 fast_i = ~fast_i; end
    initial begin slow_i = 0; #7 forever #150 slow_i = ~slow_i; end
    initial begin sec_i = 0; #11 forever #100 sec_i = ~sec_i; end
    initial begin cpu_i = 0; #2 forever #30 cpu_i = ~cpu_i; end

    // Edge history of the device and watchdog clocks, and the hang limit
    always @(posedge clock_i) begin
        sys_q <= sysclk_o;
        wdt_q <= wdt_o;
        if (wdt_o === 1'b1 && wdt_q === 1'b0) wdt_rises++;
        cycles++;
        if (cycles == 80000) begin
            failures++;
            $display("mismatch at %0t: timeout got %h expected %h", $time, cycles, 0);
            end_of_test();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic near(input int got, input int exp, input int tol);
        samples_checked++;
        if (got < exp - tol || got > exp + tol) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] d);
        @(posedge clock_i);
        addr_i  <= `CSW_OSC_CTRL_ADDR;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i   <= 1'b0;
        #1 check(rdata_o, exp);
    endtask

    // Cycles between two rising edges of the device clock, taken on the second period
    task automatic measure(output int cnt);
        int k;
        for (int p = 0; p < 2; p++) begin
            k = 0;
            do begin @(posedge clock_i); #1 k++; end
            while (!(sysclk_o === 1'b1 && sys_q === 1'b0) && k < 6000);
            cnt = k;
        end
    endtask

    task automatic sleep_pulse(input logic [7:0] exp);
        @(posedge clock_i);
        sleep_i <= 1'b1;
        @(posedge clock_i);
        sleep_i <= 1'b0;
        #1 check({6'h0, idle_o, sleep_o}, exp);
        @(posedge clock_i);
        #1 check({6'h0, idle_o, sleep_o}, 8'h00);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        {wr_i, rd_i, sleep_i, low_freq_i, sec_en_i, dig_i, two_speed_i, sec_ok_i} = '0;
        {failures, samples_checked, cycles, wdt_rises} = '0;
        reset_n_i = 0; addr_i = '0; wdata_i = '0; mode_i = 3'b010;
        done_i = 1; fast_ok_i = 1;
        repeat (10) @(posedge clock_i);
        reset_n_i <= 1'b1;
        repeat (10) @(posedge clock_i);
        rd(`CSW_OSC_CTRL_ADDR, 8'h6c);
        rd(12'h000, 8'h00);
        measure(n); near(n, 6, 2);
        $display("test reset values done");

        wr(8'hff);
        rd(`CSW_OSC_CTRL_ADDR, 8'hff);
        measure(n); near(n, 8, 2);
        for (int c = 6; c >= 1; c--) begin
            wr({1'b1, 3'(c), 4'h3});
            measure(n); near(n, 8 << (7 - c), 2);
        end
        wr(8'h83);
        measure(n); near(n, 30, 3);
        low_freq_i <= 1'b1;
        measure(n); near(n, 2048, 3);
        $display("test internal frequencies done");

        wdt_rises = 0;
        repeat (600) @(posedge clock_i);
        near(wdt_rises, 20, 2);
        wr(8'h71);
        rd(`CSW_OSC_CTRL_ADDR, 8'h77);
        dig_i <= 1'b1;
        wr(8'h71);
        rd(`CSW_OSC_CTRL_ADDR, 8'h75);
        repeat (200) @(posedge clock_i);
        #1 check({6'h0, sec_act_o, sysclk_o}, 8'h00);
        sec_ok_i <= 1'b1;
        n = 0;
        while (sec_act_o !== 1'b1 && n < 400) begin @(posedge clock_i); n++; end
        check({7'h0, sec_act_o}, 8'h01);
        rd(`CSW_OSC_CTRL_ADDR, 8'h75);
        measure(n); near(n, 20, 2);
        $display("test secondary switch done");

        wr(8'h70);
        repeat (2) @(posedge clock_i);
        #1 n = 2; // Skip the edges before the pause starts
        while (!(sysclk_o === 1'b1 && sys_q === 1'b0) && n < 300) begin
            @(posedge clock_i);
            #1 n++;
        end
        near(n, 50, 25);
        rd(`CSW_OSC_CTRL_ADDR, 8'h7c);
        sleep_pulse(8'h01);
        wr(8'hf0);
        sleep_pulse(8'h02);
        wr(8'h72);
        rd(`CSW_OSC_CTRL_ADDR, 8'h7e);
        measure(n); near(n, 6, 2);
        $display("test sleep and reserved select done");

        wr(8'h73);
        @(posedge clock_i);
        reset_n_i <= 1'b0;
        done_i <= 1'b0;
        two_speed_i <= 1'b1;
        mode_i <= 3'b000;
        repeat (2) @(posedge clock_i);
        reset_n_i <= 1'b1;
        repeat (10) @(posedge clock_i);
        rd(`CSW_OSC_CTRL_ADDR, 8'h64);
        done_i <= 1'b1;
        repeat (10) @(posedge clock_i);
        rd(`CSW_OSC_CTRL_ADDR, 8'h6c);
        measure(n); near(n, 16, 2);
        $display("test second reset done");
        end_of_test();
    end
endmodule
